// [rtl/wmac_core.sv]
// top of the medium access coordinator: access machine, polling, nav, service routing
// assumes medium pins are asynchronous; service ports are on I_CLOCK
`timescale 1ns/100ps
module wmac_core #(
  parameter int CFP_SLOTS = wmac_pkg::CFP_SLOTS,
  parameter int CP_SLOTS  = wmac_pkg::CP_SLOTS
) (
  input  wire logic                                  I_CLOCK,
  input  wire logic                                  I_RSTN,
  input  wire logic                                  I_PHY_CCA,
  input  wire logic                                  I_PHY_RX_DONE,
  input  wire logic [wmac_pkg::NAV_BITS-1:0]         I_PHY_RX_DUR,
  input  wire logic                                  I_PHY_RX_CTS,
  input  wire logic                                  I_PHY_RX_MORE,
  input  wire logic [wmac_pkg::LEN_BITS-1:0]         I_PHY_RX_LEN,
  input  wire logic                                  I_PHY_TX_DONE,
  input  wire logic                                  I_IS_AP,
  input  wire logic                                  I_PCF_EN,
  input  wire wmac_pkg::wmac_req_s                   I_REQ,
  output logic                                       O_REQ_READY,
  output wmac_pkg::wmac_ind_s                        O_IND,
  output logic                                       O_TX_START,
  output logic                                       O_TX_RTS,
  output logic                                       O_TX_POLL,
  output logic [wmac_pkg::LEN_BITS-1:0]              O_TX_LEN,
  output logic                                       O_TX_FRAG_MORE,
  output logic                                       O_MGMT_START,
  output wmac_pkg::wmac_mgmt_e                       O_MGMT_OP,
  output logic                                       O_CFP_ACTIVE
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_GAP, ST_DEFER, ST_BACKOFF, ST_RTS, ST_WAIT_CTS, ST_TX, ST_WAIT_DONE
  } wmac_st_e;

  // two-flop sync of carrier sense and both done pins, then a delay flop on each done for edge detect
  logic [1:0] cca_sync, rxd_sync, txd_sync;
  logic       rxd_d_reg, txd_d_reg;
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      cca_sync  <= 2'h0;
      rxd_sync  <= 2'h0;
      txd_sync  <= 2'h0;
      rxd_d_reg <= 1'b0;
      txd_d_reg <= 1'b0;
    end else begin
      cca_sync  <= {cca_sync[0], I_PHY_CCA};
      rxd_sync  <= {rxd_sync[0], I_PHY_RX_DONE};
      txd_sync  <= {txd_sync[0], I_PHY_TX_DONE};
      rxd_d_reg <= rxd_sync[1];
      txd_d_reg <= txd_sync[1];
    end
  end
  wire rx_done = rxd_sync[1] & ~rxd_d_reg;
  wire tx_done = txd_sync[1] & ~txd_d_reg;

  // slot divider: one-cycle enable per slot
  logic [15:0] div_reg, div_next;
  wire slot_tick = (div_reg == 16'(wmac_pkg::SLOT_CYC - 1));
  always_comb div_next = slot_tick ? 16'h0000 : div_reg + 16'h0001;
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) div_reg <= 16'h0000;
    else         div_reg <= div_next;
  end

  // virtual carrier sense: load larger announced duration, count down per slot
  logic [wmac_pkg::NAV_BITS-1:0] nav_reg, nav_next;
  always_comb begin
    nav_next = nav_reg;
    if (rx_done && I_PHY_RX_DUR > nav_reg)
      nav_next = I_PHY_RX_DUR;
    else if (slot_tick && nav_reg != '0)
      nav_next = nav_reg - 1'b1;
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) nav_reg <= '0;
    else         nav_reg <= nav_next;
  end
  // busy when either physical or virtual sense says so; nav also shields others' polled periods
  wire medium_busy = cca_sync[1] | (nav_reg != '0);

  // contention-free / contention alternation, only at an access point
  logic        cfp_reg, cfp_next;
  logic [15:0] per_reg, per_next;
  wire pcf_on = I_IS_AP & I_PCF_EN;
  always_comb begin
    cfp_next = cfp_reg;
    per_next = per_reg;
    if (!pcf_on) begin
      cfp_next = 1'b0;
      per_next = 16'h0000;
    end else if (slot_tick) begin
      if (cfp_reg && per_reg == 16'(CFP_SLOTS - 1)) begin
        cfp_next = 1'b0;
        per_next = 16'h0000;
      end else if (!cfp_reg && per_reg == 16'(CP_SLOTS - 1)) begin
        cfp_next = 1'b1;
        per_next = 16'h0000;
      end else begin
        per_next = per_reg + 16'h0001;
      end
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      cfp_reg <= 1'b0;
      per_reg <= 16'h0000;
    end else begin
      cfp_reg <= cfp_next;
      per_reg <= per_next;
    end
  end

  // access machine: gap, defer, backoff (a frozen count resumes, no redraw), optional rts, fragment transmit
  wmac_st_e                      st_reg, st_next;
  logic [3:0]                    gap_reg, gap_next;
  logic                          def_reg, def_next;
  logic                          rts_reg, rts_next;
  logic [wmac_pkg::LEN_BITS-1:0] rem_reg, rem_next;
  logic                          tx_reg, tx_next;
  logic                          txr_reg, txr_next;
  logic                          poll_reg, poll_next;
  logic                          more_reg, more_next;
  logic [wmac_pkg::LEN_BITS-1:0] txl_reg, txl_next;
  logic                          mst_reg, mst_next;
  wmac_pkg::wmac_mgmt_e          mop_reg, mop_next;
  logic                          draw;
  logic                          bo_zero;
  wire [3:0] gap_need = cfp_reg ? 4'(wmac_pkg::PIFS_SLOTS) : 4'(wmac_pkg::DIFS_SLOTS);
  wire [wmac_pkg::LEN_BITS-1:0] frag_len =
    (rem_reg > wmac_pkg::LEN_BITS'(wmac_pkg::FRAG_THRESH)) ? wmac_pkg::LEN_BITS'(wmac_pkg::FRAG_THRESH) : rem_reg;

  always_comb begin
    st_next   = st_reg;
    gap_next  = gap_reg;
    def_next  = def_reg;
    rts_next  = rts_reg;
    rem_next  = rem_reg;
    tx_next   = 1'b0;
    txr_next  = 1'b0;
    poll_next = 1'b0;
    more_next = more_reg;
    txl_next  = txl_reg;
    mst_next  = 1'b0;
    mop_next  = mop_reg;
    draw      = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        if (I_REQ.valid) begin
          rts_next = I_REQ.use_rts & ~I_REQ.is_mgmt;
          rem_next = I_REQ.length;
          mop_next = I_REQ.mgmt_op;
          mst_next = I_REQ.is_mgmt;
          gap_next = 4'h0;
          def_next = 1'b0;
          st_next  = I_REQ.is_mgmt ? ST_IDLE : ST_GAP;
        end
      end
      ST_GAP: begin
        if (medium_busy) begin
          gap_next = 4'h0;
          def_next = 1'b1;
        end else if (slot_tick) begin
          if (gap_reg + 4'h1 >= gap_need) begin
            if (def_reg && !cfp_reg) begin
              draw    = bo_zero;
              st_next = ST_BACKOFF;
            end else begin
              st_next = rts_reg ? ST_RTS : ST_TX;
            end
          end else begin
            gap_next = gap_reg + 4'h1;
          end
        end
      end
      ST_BACKOFF: begin
        if (medium_busy) begin
          gap_next = 4'h0;
          st_next  = ST_GAP;
        end else if (bo_zero) begin
          st_next = rts_reg ? ST_RTS : ST_TX;
        end
      end
      ST_RTS: begin
        txr_next = 1'b1;
        st_next  = ST_WAIT_CTS;
      end
      ST_WAIT_CTS: begin
        if (rx_done) begin
          if (I_PHY_RX_CTS) begin
            st_next = ST_TX;
          end else begin
            def_next = 1'b1;
            gap_next = 4'h0;
            st_next  = ST_GAP;
          end
        end
      end
      ST_TX: begin
        tx_next   = 1'b1;
        poll_next = cfp_reg;
        txl_next  = frag_len;
        more_next = (rem_reg > frag_len);
        rem_next  = rem_reg - frag_len;
        st_next   = ST_WAIT_DONE;
      end
      ST_WAIT_DONE: begin
        if (tx_done) begin
          gap_next = 4'h0;
          def_next = 1'b0;
          if (more_reg) st_next = ST_GAP;
          else          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      st_reg   <= ST_IDLE;
      gap_reg  <= 4'h0;
      def_reg  <= 1'b0;
      rts_reg  <= 1'b0;
      rem_reg  <= '0;
      tx_reg   <= 1'b0;
      txr_reg  <= 1'b0;
      poll_reg <= 1'b0;
      more_reg <= 1'b0;
      txl_reg  <= '0;
      mst_reg  <= 1'b0;
      mop_reg  <= wmac_pkg::WMAC_MG_ASSOC;
    end else begin
      st_reg   <= st_next;
      gap_reg  <= gap_next;
      def_reg  <= def_next;
      rts_reg  <= rts_next;
      rem_reg  <= rem_next;
      tx_reg   <= tx_next;
      txr_reg  <= txr_next;
      poll_reg <= poll_next;
      more_reg <= more_next;
      txl_reg  <= txl_next;
      mst_reg  <= mst_next;
      mop_reg  <= mop_next;
    end
  end

  // count only in the backoff state, so the gap before it never eats the count
  wmac_backoff #(.CW_BITS(wmac_pkg::CW_BITS)) u_backoff (
    .i_clk       (I_CLOCK),
    .i_rstn      (I_RSTN),
    .i_draw      (draw),
    .i_slot_tick (slot_tick),
    .i_free      (~medium_busy & (st_reg == ST_BACKOFF)),
    .o_zero      (bo_zero),
    .o_count     ()
  );

  // receive side: count fragment lengths, indicate upward on last one
  logic [wmac_pkg::LEN_BITS-1:0] acc_reg, acc_next;
  wmac_pkg::wmac_ind_s           ind_reg, ind_next;
  always_comb begin
    acc_next       = acc_reg;
    ind_next       = '0;
    if (rx_done && !I_PHY_RX_CTS) begin
      if (I_PHY_RX_MORE) begin
        acc_next = acc_reg + I_PHY_RX_LEN;
      end else begin
        ind_next.valid  = 1'b1;
        ind_next.last   = 1'b1;
        ind_next.length = acc_reg + I_PHY_RX_LEN;
        acc_next        = '0;
      end
    end else if (mst_reg) begin
      ind_next.valid   = 1'b1;
      ind_next.is_mgmt = 1'b1;
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      acc_reg <= '0;
      ind_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      ind_reg <= ind_next;
    end
  end

  assign O_REQ_READY    = (st_reg == ST_IDLE);
  assign O_IND          = ind_reg;
  assign O_TX_START     = tx_reg;
  assign O_TX_RTS       = txr_reg;
  assign O_TX_POLL      = poll_reg;
  assign O_TX_LEN       = txl_reg;
  assign O_TX_FRAG_MORE = more_reg;
  assign O_MGMT_START   = mst_reg;
  assign O_MGMT_OP      = mop_reg;
  assign O_CFP_ACTIVE   = cfp_reg;

  sequence s_busy_gap;
    (st_reg == ST_GAP) && medium_busy;
  endsequence
  property p_busy_no_tx;
    @(posedge I_CLOCK) disable iff (!I_RSTN) s_busy_gap |=> !tx_reg;
  endproperty
  a_busy_no_tx: assert property (p_busy_no_tx) else $error("transmit while busy");
  property p_nav_load;
    @(posedge I_CLOCK) disable iff (!I_RSTN)
      (rx_done && I_PHY_RX_DUR > nav_reg) |=> (nav_reg == $past(I_PHY_RX_DUR));
  endproperty
  a_nav_load: assert property (p_nav_load) else $error("nav not loaded");
  property p_cfp_ap;
    @(posedge I_CLOCK) disable iff (!I_RSTN) cfp_reg |-> $past(pcf_on);
  endproperty
  a_cfp_ap: assert property (p_cfp_ap) else $error("cfp without access point");
  property p_frag_len;
    @(posedge I_CLOCK) disable iff (!I_RSTN)
      tx_reg |-> (txl_reg <= wmac_pkg::LEN_BITS'(wmac_pkg::FRAG_THRESH));
  endproperty
  a_frag_len: assert property (p_frag_len) else $error("fragment too long");
  property p_route;
    @(posedge I_CLOCK) disable iff (!I_RSTN)
      (O_REQ_READY && I_REQ.valid) |=> (mst_reg == $past(I_REQ.is_mgmt));
  endproperty
  a_route: assert property (p_route) else $error("request misrouted");
  property p_rts_then_tx;
    @(posedge I_CLOCK) disable iff (!I_RSTN) txr_reg |-> !tx_reg ##1 (st_reg == ST_WAIT_CTS);
  endproperty
  a_rts_then_tx: assert property (p_rts_then_tx) else $error("rts order wrong");
  property p_mgmt_ind;
    @(posedge I_CLOCK) disable iff (!I_RSTN)
      (mst_reg && !(rx_done && !I_PHY_RX_CTS)) |=> (O_IND.valid && O_IND.is_mgmt);
  endproperty
  a_mgmt_ind: assert property (p_mgmt_ind) else $error("indication lost");
  property p_tx_from_access;
    @(posedge I_CLOCK) disable iff (!I_RSTN) tx_reg |-> $past(st_reg == ST_TX);
  endproperty
  a_tx_from_access: assert property (p_tx_from_access) else $error("stray transmit");
endmodule : wmac_core

// [rtl/wmac_pkg.sv]
// package for the medium access coordinator: constants, enums, structs
// assumes one 40 MHz clock; all users write wmac_pkg::name
// Operation
// - contention access always present in every station
// - sense medium before any transmit attempt
// - medium idle for full gap before sending
// - defer while medium busy until it ends
// - random backoff, decrement only while free
// - optional request/clear exchange before data
// - polled access only at access point master
// - polled access built on distributed access
// - coordinator uses shorter gap than data gap
// - coordinator seizes free medium, bounded contention-free
// - contention-free period then contention period alternate
// - never disturb others' contention-free traffic
// - fragment on send, reassemble on receive
// - route requests to data or management
// - pass state machine indications upward
// - management sequencing for association, sync, power, auth
// - virtual carrier sense allocation timer
package wmac_pkg;
  localparam int SLOT_NS       = 1000;
  localparam int CLK_NS        = 25;
  localparam int SLOT_CYC      = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIFS_SLOTS    = 3;
  localparam int PIFS_SLOTS    = 2;
  localparam int CW_BITS       = 5;
  localparam int NAV_BITS      = 16;
  localparam int CFP_SLOTS     = 64;
  localparam int CP_SLOTS      = 64;
  localparam int LEN_BITS      = 12;
  localparam int FRAG_THRESH   = 256;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  typedef enum logic [1:0] {
    WMAC_REQ_DATA,
    WMAC_REQ_MGMT,
    WMAC_REQ_NONE
  } wmac_req_e;

  typedef enum logic [2:0] {
    WMAC_MG_ASSOC,
    WMAC_MG_REASSOC,
    WMAC_MG_MIB,
    WMAC_MG_SYNC,
    WMAC_MG_POWER,
    WMAC_MG_AUTH
  } wmac_mgmt_e;

  typedef struct packed {
    logic                valid;
    logic                is_mgmt;
    wmac_mgmt_e          mgmt_op;
    logic                use_rts;
    logic [LEN_BITS-1:0] length;
  } wmac_req_s;

  typedef struct packed {
    logic                valid;
    logic                is_mgmt;
    logic                last;
    logic [LEN_BITS-1:0] length;
  } wmac_ind_s;
endpackage : wmac_pkg

// [rtl/wmac_backoff.sv]
// backoff counter with random draw from an lfsr
// assumes slot_tick is a one-cycle enable from the top's divider
`timescale 1ns/100ps
module wmac_backoff #(
  parameter int CW_BITS = wmac_pkg::CW_BITS
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_draw,
  input  wire logic               i_slot_tick,
  input  wire logic               i_free,
  output logic                    o_zero,
  output logic [CW_BITS-1:0]      o_count
);
  logic [15:0]        lfsr_reg, lfsr_next;
  logic [CW_BITS-1:0] cnt_reg, cnt_next;

  // draw loads a random count; decrement only on free slots
  always_comb begin
    lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ wmac_pkg::LFSR_TAPS) : (lfsr_reg >> 1);
    cnt_next  = cnt_reg;
    if (i_draw) begin
      cnt_next = lfsr_reg[CW_BITS-1:0];
    end else if (i_slot_tick && i_free && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      lfsr_reg <= wmac_pkg::LFSR_SEED;
      cnt_reg  <= '0;
    end else begin
      lfsr_reg <= lfsr_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign o_zero  = (cnt_reg == '0);
  assign o_count = cnt_reg;

  property p_freeze;
    @(posedge i_clk) disable iff (!i_rstn)
      (!i_free && !i_draw) |=> (cnt_reg == $past(cnt_reg));
  endproperty
  a_freeze: assert property (p_freeze) else $error("backoff moved while busy");
endmodule : wmac_backoff

// [testbench/wmac_phy_model.sv]
// physical layer model: carrier sense, transmit done, frame receive
// assumes coordinator pulses are sampled on the rising edge of i_clk
`timescale 1ns/100ps
module wmac_phy_model (
  input  wire logic        i_clk,
  input  wire logic        i_tx_start,
  input  wire logic        i_tx_rts,
  input  wire logic        i_cts_ok,
  input  wire logic        i_ext_busy,
  output logic             o_cca,
  output logic             o_rx_done,
  output logic [15:0]      o_rx_dur,
  output logic             o_rx_cts,
  output logic             o_rx_more,
  output logic [11:0]      o_rx_len,
  output logic             o_tx_done
);
  logic tx_busy = 1'b0;
  logic rx_busy = 1'b0;

  // medium busy for other stations, our own frame, or a frame arriving
  assign o_cca = i_ext_busy | tx_busy | rx_busy;

  initial begin
    o_rx_done = 1'b0;
    o_tx_done = 1'b0;
    {o_rx_dur, o_rx_cts, o_rx_more, o_rx_len} = '0;
  end

  // fields held around the done edge, then scrambled like a released line
  task automatic rx_frame(input logic [15:0] dur, input logic cts, input logic more, input logic [11:0] len);
    @(negedge i_clk);
    rx_busy = 1'b1;
    {o_rx_dur, o_rx_cts, o_rx_more, o_rx_len} = {dur, cts, more, len};
    repeat (8) @(negedge i_clk);
    o_rx_done = 1'b1;
    repeat (6) @(negedge i_clk);
    o_rx_done = 1'b0;
    repeat (2) @(negedge i_clk);
    {o_rx_dur, o_rx_cts, o_rx_more, o_rx_len} = ~{dur, cts, more, len};
    rx_busy = 1'b0;
  endtask : rx_frame

  // a data frame stays on air 20 cycles; done is a level long enough to sync
  always begin
    @(posedge i_clk);
    if (i_tx_start === 1'b1) begin
      @(negedge i_clk);
      tx_busy = 1'b1;
      repeat (20) @(negedge i_clk);
      tx_busy = 1'b0;
      o_tx_done = 1'b1;
      repeat (4) @(negedge i_clk);
      o_tx_done = 1'b0;
    end
  end

  // reply to a request-to-send; a wrong frame type only when the bench says so
  always begin
    @(posedge i_clk);
    if (i_tx_rts === 1'b1) begin
      repeat (4) @(negedge i_clk);
      rx_frame(16'h0000, i_cts_ok, 1'b0, 12'h00E);
    end
  end
endmodule : wmac_phy_model

// [testbench/tb.sv]
// self-checking bench for the medium access coordinator
// assumes the phy model on the medium side; inputs change on falling edges
`timescale 1ns/100ps
module tb;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 is_ap = 1'b0;
  logic                 pcf_en = 1'b0;
  logic                 cts_ok = 1'b1;
  logic                 ext_busy = 1'b0;
  wmac_pkg::wmac_req_s  req = '0;
  wmac_pkg::wmac_ind_s  ind;
  wmac_pkg::wmac_ind_s  last_ind;
  wmac_pkg::wmac_mgmt_e mop;
  logic                 cca, rx_done, rx_cts, rx_more, tx_done, ready;
  logic                 tx_start, tx_rts, tx_poll, frag_more, mstart, cfp;
  logic [15:0]          rx_dur;
  logic [11:0]          rx_len, tx_len;
  int                   n_fail = 0;
  int                   n_checks = 0;
  int                   n_ind = 0;
  int                   cycles = 0;

  always #12.5 clk = ~clk;

  wmac_core #(.CFP_SLOTS(4), .CP_SLOTS(4)) dut (
    .I_CLOCK(clk), .I_RSTN(rstn), .I_PHY_CCA(cca), .I_PHY_RX_DONE(rx_done),
    .I_PHY_RX_DUR(rx_dur), .I_PHY_RX_CTS(rx_cts), .I_PHY_RX_MORE(rx_more),
    .I_PHY_RX_LEN(rx_len), .I_PHY_TX_DONE(tx_done), .I_IS_AP(is_ap), .I_PCF_EN(pcf_en),
    .I_REQ(req), .O_REQ_READY(ready), .O_IND(ind), .O_TX_START(tx_start), .O_TX_RTS(tx_rts),
    .O_TX_POLL(tx_poll), .O_TX_LEN(tx_len), .O_TX_FRAG_MORE(frag_more),
    .O_MGMT_START(mstart), .O_MGMT_OP(mop), .O_CFP_ACTIVE(cfp));

  wmac_phy_model phy (
    .i_clk(clk), .i_tx_start(tx_start), .i_tx_rts(tx_rts), .i_cts_ok(cts_ok),
    .i_ext_busy(ext_busy), .o_cca(cca), .o_rx_done(rx_done), .o_rx_dur(rx_dur),
    .o_rx_cts(rx_cts), .o_rx_more(rx_more), .o_rx_len(rx_len), .o_tx_done(tx_done));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // ceiling well above the sum of all scenario waits
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_of_test();
    end
  end

  // indications are pulses, so a monitor catches them all
  always @(negedge clk) begin
    if (ind.valid === 1'b1) begin
      n_ind++;
      last_ind = ind;
    end
  end

  function automatic logic sig(input int k);
    case (k)
      0: return tx_start;
      1: return tx_rts;
      2: return mstart;
      3: return ind.valid;
      default: return cfp;
    endcase
  endfunction : sig

  task automatic wait_for(input int k, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig(k) !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_for

  // request held until the edge that sees ready, then dropped
  task automatic send_req(input logic mg, input wmac_pkg::wmac_mgmt_e op, input logic rts, input logic [11:0] len);
    req = '{valid: 1'b1, is_mgmt: mg, mgmt_op: op, use_rts: rts, length: len};
    for (int k = 0; k < 4000 && ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    req.valid = 1'b0;
  endtask : send_req

  // let the last frame finish so scenarios never overlap on the medium
  task automatic settle();
    for (int k = 0; k < 4000 && ready !== 1'b1; k++) @(negedge clk);
    repeat (40) @(negedge clk);
  endtask : settle

  task automatic t_frag();
    logic [11:0] el [3] = '{12'h100, 12'h100, 12'h058};
    int n;
    send_req(1'b0, wmac_pkg::WMAC_MG_ASSOC, 1'b0, 12'h258);
    check("ready_low", {15'h0000, ready}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wait_for(0, 1'b1, 400, n);
      check("gap", 16'(n >= (i == 0 ? 78 : 98) && n <= 220), 16'h0001);
      check("frag_len", {4'h0, tx_len}, {4'h0, el[i]});
      check("frag_more", {15'h0000, frag_more}, {15'h0000, i < 2});
      @(negedge clk);
    end
  endtask : t_frag

  task automatic t_defer();
    int n;
    ext_busy = 1'b1;
    send_req(1'b0, wmac_pkg::WMAC_MG_ASSOC, 1'b0, 12'h040);
    wait_for(0, 1'b1, 300, n);
    check("busy_hold", 16'(n), 16'h012C);
    ext_busy = 1'b0;
    wait_for(0, 1'b1, 70, n);
    check("idle_gap", 16'(n), 16'h0046);
    ext_busy = 1'b1;
    wait_for(0, 1'b1, 400, n);
    check("freeze", 16'(n), 16'h0190);
    ext_busy = 1'b0;
    wait_for(0, 1'b1, 1500, n);
    check("backoff_end", 16'(n >= 78 && n < 1500), 16'h0001);
  endtask : t_defer

  task automatic t_rts();
    int n;
    cts_ok = 1'b0;
    send_req(1'b0, wmac_pkg::WMAC_MG_ASSOC, 1'b1, 12'h020);
    wait_for(1, 1'b1, 400, n);
    check("rts", 16'(n < 400), 16'h0001);
    wait_for(0, 1'b1, 30, n);
    check("no_cts_hold", 16'(n), 16'h001E);
    cts_ok = 1'b1;
    wait_for(1, 1'b1, 1600, n);
    check("rts_retry", 16'(n < 1600), 16'h0001);
    wait_for(0, 1'b1, 400, n);
    check("data_after_cts", 16'(n < 400), 16'h0001);
  endtask : t_rts

  task automatic t_rx_nav();
    int n;
    int k;
    k = n_ind;
    phy.rx_frame(16'h0000, 1'b0, 1'b1, 12'h064);
    check("ind_mid", 16'(n_ind - k), 16'h0000);
    phy.rx_frame(16'h0008, 1'b0, 1'b0, 12'h032);
    check("ind_cnt", 16'(n_ind - k), 16'h0001);
    check("ind_len", {4'h0, last_ind.length}, 16'h0096);
    check("ind_last", {15'h0000, last_ind.last}, 16'h0001);
    send_req(1'b0, wmac_pkg::WMAC_MG_ASSOC, 1'b0, 12'h010);
    wait_for(0, 1'b1, 2000, n);
    check("nav_wait", 16'(n >= 260 && n < 2000), 16'h0001);
  endtask : t_rx_nav

  // every management operation goes to the management side, none to the medium
  task automatic t_mgmt();
    wmac_pkg::wmac_mgmt_e op;
    int n;
    for (int i = 0; i < 6; i++) begin
      op = wmac_pkg::wmac_mgmt_e'(i);
      send_req(1'b1, op, 1'b0, 12'h000);
      wait_for(2, 1'b1, 5, n);
      check("mgmt_lat", 16'(n), 16'h0000);
      check("mgmt_op", {13'h0000, mop}, {13'h0000, op});
      check("mgmt_tx", {15'h0000, tx_start}, 16'h0000);
      wait_for(3, 1'b1, 5, n);
      check("mgmt_ind", 16'(n), 16'h0001);
      check("mgmt_ind_kind", {15'h0000, ind.is_mgmt}, 16'h0001);
      check("mgmt_idle", {15'h0000, ready}, 16'h0001);
    end
  endtask : t_mgmt

  task automatic t_pcf();
    int n;
    is_ap = 1'b1;
    wait_for(4, 1'b1, 600, n);
    check("cfp_no_en", 16'(n), 16'h0258);
    is_ap = 1'b0;
    pcf_en = 1'b1;
    wait_for(4, 1'b1, 600, n);
    check("cfp_no_ap", 16'(n), 16'h0258);
    is_ap = 1'b1;
    wait_for(4, 1'b1, 600, n);
    check("cfp_on", 16'(n < 600), 16'h0001);
    wait_for(4, 1'b0, 300, n);
    check("cfp_len", 16'(n >= 150 && n <= 170), 16'h0001);
    wait_for(4, 1'b1, 300, n);
    check("cp_len", 16'(n >= 150 && n <= 170), 16'h0001);
    send_req(1'b0, wmac_pkg::WMAC_MG_ASSOC, 1'b0, 12'h020);
    wait_for(0, 1'b1, 170, n);
    check("pifs", 16'(n >= 38 && n <= 86), 16'h0001);
    check("poll", {15'h0000, tx_poll}, 16'h0001);
  endtask : t_pcf

  initial begin
    repeat (10) @(negedge clk);
    check("rst_ready", {15'h0000, ready}, 16'h0001);
    check("rst_outs", {10'h000, tx_start, tx_rts, tx_poll, mstart, cfp, ind.valid}, 16'h0000);
    rstn = 1'b1;
    t_frag();
    settle();
    t_defer();
    settle();
    t_rts();
    settle();
    t_rx_nav();
    settle();
    t_mgmt();
    t_pcf();
    end_of_test();
  end
endmodule : tb
